// ===== logic/rfs_regs.vh
`ifndef RFS_REGS_VH
`define RFS_REGS_VH

// ----------------------------------------
// Timebase
// ----------------------------------------
`define RFS_CLK_HZ          10000000
// Alert must follow the current comparator within this time (ns)
`define RFS_ALERT_MAX_NS    2000
// Overcurrent fault timer window (ns): 7.5 us to 11 us
`define RFS_OC_MIN_NS       7500
`define RFS_OC_MAX_NS       11000
// Cross-output shutdown limit (ns)
`define RFS_XSHUT_MAX_NS    10000
// Imbalance persistence (us) and thermal minimum (us)
`define RFS_IMB_US          1000
`define RFS_THERM_MIN_US    100

// Cycle counts: the overcurrent minimum rounds up; the other times are whole cycles
`define RFS_OC_CYC      ((`RFS_OC_MIN_NS * (`RFS_CLK_HZ / 1000000) + 999) / 1000)
`define RFS_IMB_CYC     (`RFS_IMB_US * (`RFS_CLK_HZ / 1000000))
`define RFS_THERM_CYC   (`RFS_THERM_MIN_US * (`RFS_CLK_HZ / 1000000))

// ----------------------------------------
// Fault flag field positions
// ----------------------------------------
`define RFS_F_OC        0
`define RFS_F_WOC       1
`define RFS_F_IMB       2
`define RFS_F_UV        3
`define RFS_F_OV        4
`define RFS_F_TH        5
`define RFS_F_XSHUT     6
`define RFS_F_W         7

// ----------------------------------------
// Widths
// ----------------------------------------
`define RFS_OC_CW       7
`define RFS_LONG_CW     14

`endif

// ===== logic/rfs_supervisor.v
`timescale 1ns/10ps
`include "rfs_regs.vh"

// Summary of operation
// - Current monitor at or above threshold pulls thermal alert low within 2 us.
// - Persisting overcurrent runs fault timer; flags overcurrent fault after 7.5-11 us.
// - Overcurrent fault tri-states phases, shuts down, drops power-good.
// - Overcurrent fault in one output shuts other output within 10 us.
// - Overcurrent clearing before expiry clears timer and releases alert.
// - Severe overcurrent shuts down at once and shuts the other output.
// - Phase sense mismatch above 9 mV for 1 ms latches imbalance fault.
// - Output 325 mV under target flags undervoltage, drops power-good, tri-states.
// - Output 325 mV over target flags overvoltage, drops power-good, clamps low side.
// - Low side stays on until output is below target, then tri-states.
// - Clamp repeats whenever output rises above overvoltage threshold again.
// - Temperature pin at warning level pulls alert low, starts fault counter.
// - Thermal counter counts up at warning, down above it.
// - Warning comparison has 20 mV hysteresis via reset level after trip.
// - Temperature pin at shutdown level flags thermal fault and shuts down.
// - Thermal fault on either monitor shuts down both outputs.
// - Alert released only after both temperature pins exceed reset level.
// - Power-good stays latched low after faults until fault reset.
// - Enable low or supply reset clears faults; restart with soft-start.
module rfs_supervisor
(
    // Clock and reset
    input  wire       clk_sys,
    input  wire       rst_n,
    // Fault reset sources
    input  wire       enable,
    input  wire       supply_ok,
    // Main output comparators
    input  wire       main_load_current_monitor_trip,
    input  wire       main_severe_overcurrent_trip,
    input  wire       main_phase_imbalance_trip,
    input  wire       main_under_trip,
    input  wire       main_over_trip,
    input  wire       main_below_target,
    input  wire       main_regulated,
    // Secondary output comparators
    input  wire       sec_load_current_monitor_trip,
    input  wire       sec_severe_overcurrent_trip,
    input  wire       sec_phase_imbalance_trip,
    input  wire       sec_under_trip,
    input  wire       sec_over_trip,
    input  wire       sec_below_target,
    input  wire       sec_regulated,
    // Main temperature pin comparators
    input  wire       main_temp_at_warn,
    input  wire       main_temp_above_reset,
    input  wire       main_temp_at_shut,
    // Secondary temperature pin comparators
    input  wire       secondary_temp_sense_pin_at_warn,
    input  wire       secondary_temp_sense_pin_above_reset,
    input  wire       secondary_temp_sense_pin_at_shut,
    // Host signals
    output wire       thermal_alert_n,
    output reg        main_power_good_r,
    output reg        sec_power_good_r,
    // Power stage control
    output reg        main_run_r,
    output reg        main_tristate_r,
    output reg        main_low_side_on_r,
    output reg        sec_run_r,
    output reg        sec_tristate_r,
    output reg        sec_low_side_on_r,
    output reg        soft_start_r,
    // Fault flags
    output reg  [6:0] main_fault_r,
    output reg  [6:0] sec_fault_r
);

    localparam integer            OC_LIM_I  = `RFS_OC_CYC;
    localparam integer            IMB_LIM_I = `RFS_IMB_CYC;
    // Counts are plain integers; keep only the counter width
    localparam [`RFS_OC_CW-1:0]   OC_LIM    = OC_LIM_I[`RFS_OC_CW-1:0];
    localparam [`RFS_LONG_CW-1:0] IMB_LIM   = IMB_LIM_I[`RFS_LONG_CW-1:0];

    // Clamp states
    localparam [1:0] CL_IDLE = 2'b00;
    localparam [1:0] CL_ON   = 2'b01;
    localparam [1:0] CL_OFF  = 2'b10;

    wire clr;
    wire th_main_warn;
    wire th_main_fault;
    wire th_sec_warn;
    wire th_sec_fault;
    wire th_any;
    wire main_clamp;
    wire sec_clamp;

    reg  [`RFS_OC_CW-1:0]   main_oc_cnt_r;
    reg  [`RFS_OC_CW-1:0]   sec_oc_cnt_r;
    reg  [`RFS_LONG_CW-1:0] main_imb_cnt_r;
    reg  [`RFS_LONG_CW-1:0] sec_imb_cnt_r;
    reg  [1:0]              main_cl_r;
    reg  [1:0]              sec_cl_r;
    reg  [1:0]              main_cl_nxt;
    reg  [1:0]              sec_cl_nxt;
    reg                     en_d_r;
    reg                     oc_alert_r;
    reg                     th_alert_r;

    assign clr = !enable || !supply_ok;

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    function [`RFS_OC_CW-1:0] oc_step;
        input [`RFS_OC_CW-1:0] c;
        input                  trip;
        begin
            if (!trip)
                oc_step = {`RFS_OC_CW{1'b0}};
            else if (c != OC_LIM)
                oc_step = c + 1'b1;
            else
                oc_step = c;
        end
    endfunction

    function [`RFS_LONG_CW-1:0] imb_step;
        input [`RFS_LONG_CW-1:0] c;
        input                    trip;
        begin
            if (!trip)
                imb_step = {`RFS_LONG_CW{1'b0}};
            else if (c != IMB_LIM)
                imb_step = c + 1'b1;
            else
                imb_step = c;
        end
    endfunction

    // Clamp sequence: on while above target, off once below, rearm on new trip
    function [1:0] cl_step;
        input [1:0] s;
        input       over;
        input       below;
        begin
            case (s)
                CL_IDLE: cl_step = over ? CL_ON : CL_IDLE;
                CL_ON:   cl_step = below ? CL_OFF : CL_ON;
                CL_OFF:  cl_step = over ? CL_ON : CL_OFF;
                default: cl_step = CL_IDLE;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Thermal monitors
    // ----------------------------------------
    rfs_therm_mon u_th_main
    (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .clr         (clr),
        .at_warn     (main_temp_at_warn),
        .above_reset (main_temp_above_reset),
        .at_shut     (main_temp_at_shut),
        .warn_r      (th_main_warn),
        .fault_r     (th_main_fault)
    );

    rfs_therm_mon u_th_sec
    (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .clr         (clr),
        .at_warn     (secondary_temp_sense_pin_at_warn),
        .above_reset (secondary_temp_sense_pin_above_reset),
        .at_shut     (secondary_temp_sense_pin_at_shut),
        .warn_r      (th_sec_warn),
        .fault_r     (th_sec_fault)
    );

    assign th_any = th_main_fault || th_sec_fault;

    assign thermal_alert_n = !(oc_alert_r || th_main_warn || th_sec_warn || th_alert_r);

    // ----------------------------------------
    // Clamp next state
    // ----------------------------------------
    // repeat clamp sequence
    always @*
    begin
        main_cl_nxt = cl_step(main_cl_r, main_over_trip, main_below_target);
        sec_cl_nxt  = cl_step(sec_cl_r, sec_over_trip, sec_below_target);
    end

    // clamp only after an overvoltage, released below target
    assign main_clamp = !clr && (main_cl_nxt == CL_ON)
                        && (main_fault_r[`RFS_F_OV] || main_over_trip);
    assign sec_clamp  = !clr && (sec_cl_nxt == CL_ON)
                        && (sec_fault_r[`RFS_F_OV] || sec_over_trip);

    // ----------------------------------------
    // Fault latches and counters
    // ----------------------------------------
    always @(posedge clk_sys)
    begin
        if (!rst_n || clr)
        begin
            main_oc_cnt_r  <= {`RFS_OC_CW{1'b0}};
            sec_oc_cnt_r   <= {`RFS_OC_CW{1'b0}};
            main_imb_cnt_r <= {`RFS_LONG_CW{1'b0}};
            sec_imb_cnt_r  <= {`RFS_LONG_CW{1'b0}};
            main_cl_r      <= CL_IDLE;
            sec_cl_r       <= CL_IDLE;
            main_fault_r   <= 7'h00;
            sec_fault_r    <= 7'h00;
            oc_alert_r     <= 1'b0;
            th_alert_r     <= 1'b0;
        end
        else
        begin
            main_oc_cnt_r <= oc_step(main_oc_cnt_r, main_load_current_monitor_trip);
            sec_oc_cnt_r  <= oc_step(sec_oc_cnt_r, sec_load_current_monitor_trip);
            oc_alert_r    <= main_load_current_monitor_trip || sec_load_current_monitor_trip;
            // hold alert until both pins cool
            if (main_temp_above_reset && secondary_temp_sense_pin_above_reset)
                th_alert_r <= 1'b0;
            else if (th_main_warn || th_sec_warn)
                th_alert_r <= 1'b1;
            if (main_oc_cnt_r == OC_LIM)
                main_fault_r[`RFS_F_OC] <= 1'b1;
            if (sec_oc_cnt_r == OC_LIM)
                sec_fault_r[`RFS_F_OC] <= 1'b1;
            if (main_severe_overcurrent_trip)
                main_fault_r[`RFS_F_WOC] <= 1'b1;
            if (sec_severe_overcurrent_trip)
                sec_fault_r[`RFS_F_WOC] <= 1'b1;
            main_imb_cnt_r <= imb_step(main_imb_cnt_r, main_phase_imbalance_trip);
            sec_imb_cnt_r  <= imb_step(sec_imb_cnt_r, sec_phase_imbalance_trip);
            if (main_imb_cnt_r == IMB_LIM)
                main_fault_r[`RFS_F_IMB] <= 1'b1;
            if (sec_imb_cnt_r == IMB_LIM)
                sec_fault_r[`RFS_F_IMB] <= 1'b1;
            if (main_under_trip)
                main_fault_r[`RFS_F_UV] <= 1'b1;
            if (sec_under_trip)
                sec_fault_r[`RFS_F_UV] <= 1'b1;
            if (main_over_trip)
                main_fault_r[`RFS_F_OV] <= 1'b1;
            if (sec_over_trip)
                sec_fault_r[`RFS_F_OV] <= 1'b1;
            // Clamp runs only once an overvoltage has tripped or latched
            if (main_fault_r[`RFS_F_OV] || main_over_trip)
                main_cl_r <= main_cl_nxt;
            if (sec_fault_r[`RFS_F_OV] || sec_over_trip)
                sec_cl_r <= sec_cl_nxt;
            if (th_any)
            begin
                main_fault_r[`RFS_F_TH] <= 1'b1;
                sec_fault_r[`RFS_F_TH]  <= 1'b1;
            end
            if (main_fault_r[`RFS_F_OC] || main_fault_r[`RFS_F_WOC])
                sec_fault_r[`RFS_F_XSHUT] <= 1'b1;
            if (sec_fault_r[`RFS_F_OC] || sec_fault_r[`RFS_F_WOC])
                main_fault_r[`RFS_F_XSHUT] <= 1'b1;
        end
    end

    // ----------------------------------------
    // Power stage and power-good
    // ----------------------------------------
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            en_d_r             <= 1'b0;
            soft_start_r       <= 1'b0;
            main_run_r         <= 1'b0;
            sec_run_r          <= 1'b0;
            main_tristate_r    <= 1'b1;
            sec_tristate_r     <= 1'b1;
            main_low_side_on_r <= 1'b0;
            sec_low_side_on_r  <= 1'b0;
            main_power_good_r  <= 1'b0;
            sec_power_good_r   <= 1'b0;
        end
        else
        begin
            en_d_r       <= !clr;
            soft_start_r <= !clr && !en_d_r;
            main_run_r <= !clr && (main_fault_r == 7'h00) && !th_any;
            sec_run_r  <= !clr && (sec_fault_r == 7'h00) && !th_any;
            // A running clamp drives the low side, so the stage is not tri-stated
            main_tristate_r <= (clr || (main_fault_r != 7'h00) || th_any) && !main_clamp;
            sec_tristate_r  <= (clr || (sec_fault_r != 7'h00) || th_any) && !sec_clamp;
            main_low_side_on_r <= main_clamp;
            sec_low_side_on_r  <= sec_clamp;
            main_power_good_r <= !clr && main_regulated && (main_fault_r == 7'h00) && !th_any;
            sec_power_good_r  <= !clr && sec_regulated && (sec_fault_r == 7'h00) && !th_any;
        end
    end

endmodule // rfs_supervisor

// ===== logic/rfs_therm_mon.v
`timescale 1ns/10ps
`include "rfs_regs.vh"

module rfs_therm_mon
(
    // Clock and reset
    input  wire clk_sys,
    input  wire rst_n,
    // Fault reset (enable low or supply reset)
    input  wire clr,
    // Comparators from the sense pin
    input  wire at_warn,
    input  wire above_reset,
    input  wire at_shut,
    // Status
    output reg  warn_r,
    output reg  fault_r
);

    localparam integer            LIMIT_I = `RFS_THERM_CYC;
    localparam [`RFS_LONG_CW-1:0] LIMIT   = LIMIT_I[`RFS_LONG_CW-1:0];

    reg [`RFS_LONG_CW-1:0] cnt_r;
    reg [`RFS_LONG_CW-1:0] cnt_nxt;

    // ----------------------------------------
    // Up/down counter
    // ----------------------------------------
    // up down counting
    always @*
    begin
        cnt_nxt = cnt_r;
        if (at_warn)
        begin
            if (cnt_r != LIMIT)
                cnt_nxt = cnt_r + 1'b1;
        end
        else if (cnt_r != {`RFS_LONG_CW{1'b0}})
            cnt_nxt = cnt_r - 1'b1;
    end

    always @(posedge clk_sys)
    begin
        if (!rst_n || clr)
        begin
            cnt_r   <= {`RFS_LONG_CW{1'b0}};
            warn_r  <= 1'b0;
            fault_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            if (at_warn)
                warn_r <= 1'b1;
            else if (above_reset)
                warn_r <= 1'b0;
            if (at_shut || cnt_r == LIMIT)
                fault_r <= 1'b1;
        end
    end

endmodule // rfs_therm_mon

// ===== test/rfs_host_model.sv
`timescale 1ns/10ps
module rfs_host_model
(
    // Clock
    input  wire clk_sys,
    // Recovery request from the bench
    input  wire recover,
    // Fault reset to the regulator
    output reg  enable
);
    reg [1:0] hold_r;
    initial enable = 1'b1;
    initial hold_r = 2'h0;
    always @(posedge clk_sys)
    begin
        if (recover)
            hold_r <= 2'h3;
        else if (hold_r != 2'h0)
            hold_r <= hold_r - 2'h1;
        enable <= !recover && (hold_r == 2'h0);
    end
endmodule // rfs_host_model

// ===== test/rfs_supervisor_checker.sv
`timescale 1ns/10ps
module rfs_supervisor_checker
(
    // Clock and reset
    input wire       clk_sys,
    input wire       rst_n,
    // Watched inputs
    input wire       enable,
    input wire       supply_ok,
    input wire       main_load_current_monitor_trip,
    input wire       main_severe_overcurrent_trip,
    input wire       main_over_trip,
    input wire       main_below_target,
    input wire       main_temp_at_warn,
    input wire       main_temp_at_shut,
    // Watched outputs
    input wire       thermal_alert_n,
    input wire       main_power_good_r,
    input wire       main_run_r,
    input wire       main_tristate_r,
    input wire       main_low_side_on_r,
    input wire       sec_run_r,
    input wire [6:0] main_fault_r,
    input wire [6:0] sec_fault_r
);
    // Trips taken while a fault clear is held are ignored
    wire live = enable && supply_ok;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    alert_on_trip_a: assert property (live && (main_load_current_monitor_trip || main_temp_at_warn)
        |=> !thermal_alert_n) else $error("alert not low after trip");
    oc_hold_a: assert property ($rose(main_fault_r[0]) |-> $past(main_load_current_monitor_trip)
        && $past(main_load_current_monitor_trip, 75)) else $error("early overcurrent flag");
    oc_stop_a: assert property ($rose(main_fault_r[0]) |=> !main_run_r && main_tristate_r
        && !main_power_good_r) else $error("no shutdown on overcurrent");
    cross_shut_a: assert property ($rose(main_fault_r[0]) |-> ##[1:100]
        (sec_fault_r[6] && !sec_run_r)) else $error("other output kept running");
    woc_now_a: assert property (live && main_severe_overcurrent_trip |=> main_fault_r[1]
        ##1 (!main_run_r && !main_power_good_r)) else $error("slow severe shutdown");
    ov_clamp_a: assert property (live && main_over_trip |-> ##[1:2]
        (main_fault_r[4] && main_low_side_on_r)) else $error("no clamp on overvoltage");
    clamp_off_a: assert property (main_low_side_on_r && main_below_target && !main_over_trip
        |=> !main_low_side_on_r) else $error("clamp held below target");
    shut_both_a: assert property (live && main_temp_at_shut |-> ##[1:2]
        (main_fault_r[5] && sec_fault_r[5])) else $error("thermal shutdown missing");
    pg_latch_a: assert property (live && main_fault_r != 7'h00 |=> !main_power_good_r)
        else $error("power good high with fault");
    clear_all_a: assert property (!enable |=> main_fault_r == 7'h00 && sec_fault_r == 7'h00)
        else $error("faults kept with enable low");
endmodule // rfs_supervisor_checker

bind rfs_supervisor rfs_supervisor_checker rfs_supervisor_checker_i (.*);

// ===== test/rfs_supervisor_tb.sv
`timescale 1ns/10ps
module rfs_supervisor_tb;
    logic clk_sys, rst_n, supply_ok, recover;
    logic main_load_current_monitor_trip, main_severe_overcurrent_trip, main_phase_imbalance_trip;
    logic main_under_trip, main_over_trip, main_below_target, main_regulated;
    logic sec_load_current_monitor_trip, sec_severe_overcurrent_trip, sec_phase_imbalance_trip;
    logic sec_under_trip, sec_over_trip, sec_below_target, sec_regulated;
    logic main_temp_at_warn, main_temp_above_reset, main_temp_at_shut;
    logic secondary_temp_sense_pin_at_warn, secondary_temp_sense_pin_above_reset;
    logic secondary_temp_sense_pin_at_shut;
    wire  enable, thermal_alert_n, main_power_good_r, sec_power_good_r, soft_start_r;
    wire  main_run_r, main_tristate_r, main_low_side_on_r, sec_run_r, sec_tristate_r;
    wire  sec_low_side_on_r;
    wire  [6:0] main_fault_r, sec_fault_r;
    int   n_tests = 0;
    int   n_fail = 0;

    rfs_supervisor rfs_supervisor_i (.*);
    rfs_host_model rfs_host_model_i (.clk_sys(clk_sys), .recover(recover), .enable(enable));

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #10;
    endtask

    task automatic chk(input string what, input logic [6:0] exp, input logic [6:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Fault clear through the host or through the supply, then wait for power good
    task automatic do_recover(input bit by_supply);
        int i;
        recover = !by_supply;
        supply_ok = by_supply ? 1'b0 : 1'b1;
        step(2);
        recover = 1'b0;
        supply_ok = 1'b1;
        for (i = 0; i < 12 && soft_start_r !== 1'b1; i++)
            step(1);
        chk1("soft start", 1'b1, soft_start_r);
        step(1);
        chk1("soft start pulse", 1'b0, soft_start_r);
        chk("main faults cleared", 7'h00, main_fault_r);
        chk("sec faults cleared", 7'h00, sec_fault_r);
        for (i = 0; i < 300 && (main_power_good_r & sec_power_good_r) !== 1'b1; i++)
            step(1);
        chk("power good", 7'h03, {5'h00, main_power_good_r, sec_power_good_r});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_overcurrent;
        sec_load_current_monitor_trip = 1'b1;
        step(40);
        chk1("alert in trip", 1'b0, thermal_alert_n);
        sec_load_current_monitor_trip = 1'b0;
        step(3);
        chk1("alert released", 1'b1, thermal_alert_n);
        sec_load_current_monitor_trip = 1'b1;
        step(60);
        chk("timer restarted", 7'h00, sec_fault_r);
        sec_load_current_monitor_trip = 1'b0;
        main_load_current_monitor_trip = 1'b1;
        step(74);
        chk("oc too early", 7'h00, main_fault_r);
        step(36);
        chk("oc flagged", 7'h01, main_fault_r);
        chk("main stage", 7'h02, {4'h0, main_run_r, main_tristate_r, main_power_good_r});
        chk("cross flag", 7'h40, sec_fault_r);
        chk1("sec run", 1'b0, sec_run_r);
        main_load_current_monitor_trip = 1'b0;
        do_recover(1'b0);
    endtask

    task automatic t_severe_under;
        main_severe_overcurrent_trip = 1'b1;
        sec_severe_overcurrent_trip = 1'b1;
        step(1);
        main_severe_overcurrent_trip = 1'b0;
        sec_severe_overcurrent_trip = 1'b0;
        step(3);
        chk("severe flag", 7'h42, sec_fault_r);
        chk("sec stage", 7'h00, {5'h00, sec_run_r, sec_power_good_r});
        chk("cross severe", 7'h42, main_fault_r);
        do_recover(1'b0);
        main_under_trip = 1'b1;
        sec_under_trip = 1'b1;
        step(1);
        main_under_trip = 1'b0;
        sec_under_trip = 1'b0;
        step(3);
        chk("main uv", 7'h08, main_fault_r);
        chk("sec uv", 7'h08, sec_fault_r);
        chk1("uv tristate", 1'b1, sec_tristate_r);
        step(20);
        chk1("pg latched", 1'b0, main_power_good_r);
        do_recover(1'b1);
    endtask

    task automatic t_overvoltage;
        main_over_trip = 1'b1;
        sec_over_trip = 1'b1;
        step(1);
        main_over_trip = 1'b0;
        sec_over_trip = 1'b0;
        step(22);
        chk("ov flag", 7'h10, main_fault_r);
        chk("sec ov flag", 7'h10, sec_fault_r);
        chk("ov clamp", 7'h02, {5'h00, main_low_side_on_r, main_power_good_r});
        chk1("sec clamp", 1'b1, sec_low_side_on_r);
        chk1("clamp not tristated", 1'b0, main_tristate_r);
        main_below_target = 1'b1;
        step(3);
        main_below_target = 1'b0;
        step(5);
        chk1("clamp off", 1'b0, main_low_side_on_r);
        chk1("gate tristated", 1'b1, main_tristate_r);
        main_over_trip = 1'b1;
        step(1);
        main_over_trip = 1'b0;
        step(2);
        chk1("clamp again", 1'b1, main_low_side_on_r);
        do_recover(1'b0);
    endtask

    task automatic t_imbalance;
        main_phase_imbalance_trip = 1'b1;
        sec_phase_imbalance_trip = 1'b1;
        step(9990);
        chk("imb early", 7'h00, main_fault_r);
        step(20);
        chk("main imb", 7'h04, main_fault_r);
        chk("sec imb", 7'h04, sec_fault_r);
        main_phase_imbalance_trip = 1'b0;
        sec_phase_imbalance_trip = 1'b0;
        do_recover(1'b0);
    endtask

    task automatic t_thermal;
        main_temp_at_warn = 1'b1;
        main_temp_above_reset = 1'b0;
        step(500);
        chk1("warn alert", 1'b0, thermal_alert_n);
        main_temp_at_warn = 1'b0;
        step(500);
        chk1("hysteresis band", 1'b0, thermal_alert_n);
        main_temp_at_warn = 1'b1;
        step(990);
        chk("counted down", 7'h00, main_fault_r);
        step(20);
        chk("main thermal", 7'h20, main_fault_r);
        chk("sec thermal", 7'h20, sec_fault_r);
        main_temp_at_warn = 1'b0;
        main_temp_above_reset = 1'b1;
        secondary_temp_sense_pin_above_reset = 1'b0;
        step(3);
        chk1("one pin hot", 1'b0, thermal_alert_n);
        secondary_temp_sense_pin_above_reset = 1'b1;
        step(3);
        chk1("both pins cool", 1'b1, thermal_alert_n);
        do_recover(1'b0);
        secondary_temp_sense_pin_at_warn = 1'b1;
        secondary_temp_sense_pin_at_shut = 1'b1;
        step(1);
        secondary_temp_sense_pin_at_shut = 1'b0;
        step(3);
        chk("shut main", 7'h20, main_fault_r);
        chk("shut stage", 7'h02, {5'h00, main_tristate_r, main_power_good_r});
        secondary_temp_sense_pin_at_warn = 1'b0;
        do_recover(1'b0);
        main_temp_at_shut = 1'b1;
        step(1);
        main_temp_at_shut = 1'b0;
        step(3);
        chk("shut sec", 7'h20, sec_fault_r);
        do_recover(1'b1);
    endtask

    initial
    begin
        {main_load_current_monitor_trip, main_severe_overcurrent_trip, main_phase_imbalance_trip,
         main_under_trip, main_over_trip, main_below_target, recover} = 7'h00;
        {sec_load_current_monitor_trip, sec_severe_overcurrent_trip, sec_phase_imbalance_trip,
         sec_under_trip, sec_over_trip, sec_below_target, main_temp_at_warn} = 7'h00;
        {main_temp_at_shut, secondary_temp_sense_pin_at_warn, secondary_temp_sense_pin_at_shut} = 3'h0;
        {main_regulated, sec_regulated, supply_ok, main_temp_above_reset} = 4'hf;
        secondary_temp_sense_pin_above_reset = 1'b1;
        rst_n = 1'b0;
        step(12);
        chk("reset flags", 7'h00, main_fault_r | sec_fault_r);
        chk("reset stage", 7'h4c, {thermal_alert_n, main_power_good_r, main_run_r,
            main_tristate_r, sec_tristate_r, main_low_side_on_r, soft_start_r});
        rst_n = 1'b1;
        step(1);
        t_overcurrent;
        t_severe_under;
        t_overvoltage;
        t_imbalance;
        t_thermal;
        test_done;
    end

    // Whole run is about 12400 cycles; cut off well past that
    initial
    begin
        #5000000;
        n_fail++;
        test_done;
    end
endmodule // rfs_supervisor_tb
